// ---- design/rif_top.sv ----
/*
  Event flags, receive timeouts, pin routing and clock output selector
  of a packet radio, with an APB register slave.
  Assumes core event inputs are one-cycle pulses on i_mclk, the battery
  comparator is asynchronous, and i_mclk stands for the crystal clock.
*/
// Our own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none

module rif_top (
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset,
  // APB slave
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [11:0]          i_paddr,
  input  wire logic [31:0]          i_pwdata,
  input  wire logic [3:0]           i_pstrb,
  output logic                      o_pready,
  output logic [31:0]               o_prdata,
  output logic                      o_pslverr,
  // Radio core status
  input  wire rif_pkg::rif_mode_t   i_op_mode,
  input  wire logic                 i_mode_ready_evt,
  input  wire logic                 i_rx_settle_done,
  input  wire logic                 i_pa_ramp_done,
  input  wire logic                 i_pll_locked,
  input  wire logic [7:0]           i_strength_measure,
  input  wire logic                 i_intermediate_active,
  input  wire logic                 i_frame_match_evt,
  input  wire logic                 i_continuous_mode,
  input  wire logic [6:0]           i_queue_count,
  input  wire logic [6:0]           i_queue_mark,
  input  wire logic                 i_overrun_evt,
  input  wire logic                 i_packet_done,
  input  wire logic                 i_payload_done,
  input  wire logic                 i_check_pass,
  input  wire logic                 i_check_enable,
  input  wire logic                 i_keep_on_check_fail,
  input  wire logic                 i_bit_tick,
  input  wire logic                 i_battery_below,
  input  wire logic                 i_rc_osc,
  input  wire logic [5:0][3:0]      i_route_cand_packet,
  input  wire logic [5:0][3:0]      i_route_cand_cont,
  // Outputs
  output logic                      o_queue_clear,
  output logic                      o_rc_osc_enable,
  output logic                      o_divided_clock_pin,
  output logic [5:0]                o_aux_out_pin
);
  import rif_pkg::*;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  route_a;
    logic [7:0]  route_b;
    logic [7:0]  level;
    logic [7:0]  wait1;
    logic [7:0]  wait2;
    logic [7:0]  flags1;
    logic [7:0]  flags2;
    rif_mode_t   mode_prev;
    logic        mode_seen;
    logic [1:0]  bat_sync;
    logic [4:0]  div_cnt;
    logic        clk_pin;
    logic [5:0]  pins;
    logic [31:0] rdata;
    logic        slverr;
    logic        qclr;
  } rif_top_state_t;

  rif_top_state_t st_ff;
  rif_top_state_t nxt_st;

  rif_tmo_if tmo_start ();
  rif_tmo_if tmo_post ();

  logic       setup_ph;
  logic       wr_acc;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic       in_rx;
  logic       in_tx;
  logic       empty_evt;
  logic       check_fail;
  logic [7:0] rd_val;
  logic       rd_hit;

  // ---------------------------------------------------------------------
  // Bus and mode decode
  // ---------------------------------------------------------------------
  assign setup_ph   = i_psel && !i_penable;
  assign wr_acc     = i_psel && i_penable && i_pwrite && i_pstrb[0];
  assign idx        = i_paddr[9:2];
  assign wbyte      = i_pwdata[7:0];
  assign in_rx      = (i_op_mode == RIF_MODE_RX);
  assign in_tx      = (i_op_mode == RIF_MODE_TX);
  assign empty_evt  = (st_ff.flags2[RIF_F2_NONEMPTY] && i_queue_count == 7'h00) || st_ff.qclr;
  assign check_fail = i_payload_done && in_rx && i_check_enable && !i_check_pass;

  // ---------------------------------------------------------------------
  // Timeout counters
  // ---------------------------------------------------------------------
  // Start waits for strength, post waits for a body
  assign tmo_start.arm      = in_rx && !st_ff.flags1[RIF_F1_STRENGTH];
  assign tmo_start.units    = st_ff.wait1;
  assign tmo_start.bit_tick = i_bit_tick;
  assign tmo_post.arm       = in_rx && st_ff.flags1[RIF_F1_STRENGTH] &&
                              !st_ff.flags2[RIF_F2_BODY_RECV];
  assign tmo_post.units     = st_ff.wait2;
  assign tmo_post.bit_tick  = i_bit_tick;

  rif_timeout u_tmo_start (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .tmo     (tmo_start)
  );

  rif_timeout u_tmo_post (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .tmo     (tmo_post)
  );

  // ---------------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------------
  always_comb begin
    // Unmapped indices read zero, flag an error
    rd_val = 8'h00;
    rd_hit = 1'b1;
    unique case (idx)
      RIF_IDX_ROUTE_A: rd_val = st_ff.route_a;
      RIF_IDX_ROUTE_B: rd_val = st_ff.route_b;
      RIF_IDX_FLAGS1:  rd_val = st_ff.flags1;
      RIF_IDX_FLAGS2:  rd_val = st_ff.flags2;
      RIF_IDX_LEVEL:   rd_val = st_ff.level;
      RIF_IDX_WAIT1:   rd_val = st_ff.wait1;
      RIF_IDX_WAIT2:   rd_val = st_ff.wait2;
      default:         rd_hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    logic [7:0] f1;
    logic [7:0] f2;
    logic       sel_hi;
    logic       sel_lo;
    logic [1:0] psel_code;
    f1        = st_ff.flags1;
    f2        = st_ff.flags2;
    sel_hi    = 1'b0;
    sel_lo    = 1'b0;
    psel_code = 2'h0;
    nxt_st    = st_ff;

    // Bus: capture read data in setup, write at the access edge
    if (setup_ph) begin
      nxt_st.rdata  = {24'h000000, rd_val};
      nxt_st.slverr = !rd_hit;
    end
    // Failed check empties the queue unless kept
    nxt_st.qclr = check_fail && !i_keep_on_check_fail;

    // Software writes and clears
    if (wr_acc && !st_ff.slverr) begin
      unique case (idx)
        RIF_IDX_ROUTE_A: nxt_st.route_a = wbyte;
        RIF_IDX_ROUTE_B: begin
          nxt_st.route_b = wbyte;
          nxt_st.route_b[RIF_B_ROUTE_B_RSVD] = 1'b0;
        end
        RIF_IDX_LEVEL:   nxt_st.level = wbyte;
        RIF_IDX_WAIT1:   nxt_st.wait1 = wbyte;
        RIF_IDX_WAIT2:   nxt_st.wait2 = wbyte;
        RIF_IDX_FLAGS1: begin
          if (wbyte[RIF_F1_STRENGTH]) f1[RIF_F1_STRENGTH] = 1'b0;
          if (wbyte[RIF_F1_FRAME_MATCH] && i_continuous_mode) f1[RIF_F1_FRAME_MATCH] = 1'b0;
        end
        RIF_IDX_FLAGS2: begin
          if (wbyte[RIF_F2_OVERFLOW]) begin
            // Empties the queue and drops flags tied to its content
            nxt_st.qclr = 1'b1;
            f2[RIF_F2_OVERFLOW]     = 1'b0;
            f2[RIF_F2_BODY_RECV]    = 1'b0;
            f2[RIF_F2_CHECK_PASSED] = 1'b0;
            f1[RIF_F1_TIMEOUT]      = 1'b0;
            f1[RIF_F1_FRAME_MATCH]  = 1'b0;
          end
          if (wbyte[RIF_F2_BATTERY_LOW]) f2[RIF_F2_BATTERY_LOW] = 1'b0;
        end
        default: ;
      endcase
    end

    // Clears by hardware condition
    nxt_st.mode_prev = i_op_mode;
    nxt_st.mode_seen = 1'b1;
    // No false mode change right after reset
    if (st_ff.mode_seen && i_op_mode != st_ff.mode_prev) begin
      f1[RIF_F1_MODE_SETTLED] = 1'b0;
    end
    // Leaving a mode drops its flags
    if (!in_rx) begin
      f1[RIF_F1_RX_SETTLED]  = 1'b0;
      f1[RIF_F1_STRENGTH]    = 1'b0;
      f1[RIF_F1_TIMEOUT]     = 1'b0;
      f1[RIF_F1_FRAME_MATCH] = 1'b0;
    end
    if (!in_tx) begin
      f1[RIF_F1_TX_SETTLED]  = 1'b0;
      f2[RIF_F2_TRANSMITTED] = 1'b0;
    end
    // Queue emptied: content flags drop
    if (empty_evt) begin
      f1[RIF_F1_TIMEOUT]      = 1'b0;
      f1[RIF_F1_FRAME_MATCH]  = 1'b0;
      f2[RIF_F2_BODY_RECV]    = 1'b0;
      f2[RIF_F2_CHECK_PASSED] = 1'b0;
    end

    // Sets win over clears
    if (i_mode_ready_evt) f1[RIF_F1_MODE_SETTLED] = 1'b1;
    if (in_rx && i_rx_settle_done) f1[RIF_F1_RX_SETTLED] = 1'b1;
    if (in_tx && i_pa_ramp_done) f1[RIF_F1_TX_SETTLED] = 1'b1;
    f1[RIF_F1_SYNTH_LOCKED] = i_pll_locked && (i_op_mode == RIF_MODE_SYNTH || in_rx || in_tx);
    if (in_rx && i_strength_measure > st_ff.level) f1[RIF_F1_STRENGTH] = 1'b1;
    if (tmo_start.expire || tmo_post.expire) f1[RIF_F1_TIMEOUT] = 1'b1;
    f1[RIF_F1_INTERMEDIATE] = i_intermediate_active;
    if (in_rx && i_frame_match_evt) f1[RIF_F1_FRAME_MATCH] = 1'b1;

    // Live queue status, then sticky overflow and packet flags
    f2[RIF_F2_QUEUE_FULL]  = (i_queue_count == RIF_QUEUE_DEPTH);
    f2[RIF_F2_NONEMPTY]    = (i_queue_count != 7'h00);
    f2[RIF_F2_ABOVE_MARK]  = (i_queue_count > i_queue_mark);
    if (i_overrun_evt && i_op_mode != RIF_MODE_SLEEP) f2[RIF_F2_OVERFLOW] = 1'b1;
    if (in_tx && i_packet_done) f2[RIF_F2_TRANSMITTED] = 1'b1;
    if (i_payload_done && in_rx &&
        (!i_check_enable || i_check_pass || i_keep_on_check_fail)) begin
      f2[RIF_F2_BODY_RECV] = 1'b1;
    end
    if (i_payload_done && in_rx && i_check_pass) f2[RIF_F2_CHECK_PASSED] = 1'b1;

    // Two flops before the battery level is read
    nxt_st.bat_sync = {st_ff.bat_sync[0], i_battery_below};
    if (st_ff.bat_sync[1]) f2[RIF_F2_BATTERY_LOW] = 1'b1;

    nxt_st.flags1 = f1;
    nxt_st.flags2 = f2;

    // Clock divider
    // Counter bit n toggles every 2^n cycles
    nxt_st.div_cnt = st_ff.div_cnt + 5'h01;
    if (st_ff.route_b[2:RIF_B_CLK_SEL_LSB] != 3'h0 &&
        st_ff.route_b[2:RIF_B_CLK_SEL_LSB] <= RIF_CLK_DIV32) begin
      nxt_st.clk_pin = nxt_st.div_cnt[st_ff.route_b[2:RIF_B_CLK_SEL_LSB] - 3'h1];
    end else begin
      nxt_st.clk_pin = 1'b0;
    end

    // Pin routing
    // Pin0 takes the top selector pair
    for (int p = 0; p < 6; p++) begin
      psel_code = (p < 4) ? st_ff.route_a[7 - 2 * p -: 2] : st_ff.route_b[7 - 2 * (p - 4) -: 2];
      nxt_st.pins[p] = i_continuous_mode ? i_route_cand_cont[p][psel_code]
                                         : i_route_cand_packet[p][psel_code];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_ff         <= '0;
      st_ff.route_a <= RIF_RST_ROUTE_A;
      st_ff.route_b <= RIF_RST_ROUTE_B;
      st_ff.level   <= RIF_RST_LEVEL;
      st_ff.wait1   <= RIF_RST_WAIT;
      st_ff.wait2   <= RIF_RST_WAIT;
      st_ff.flags1  <= RIF_RST_FLAGS1;
      st_ff.flags2  <= RIF_RST_FLAGS2;
      st_ff.mode_prev <= RIF_MODE_SLEEP;
      st_ff.mode_seen <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  // No wait states
  assign o_pready        = i_psel && i_penable;
  assign o_prdata        = st_ff.rdata;
  assign o_pslverr       = i_psel && i_penable && st_ff.slverr;
  assign o_queue_clear   = st_ff.qclr;
  assign o_rc_osc_enable = (st_ff.route_b[2:RIF_B_CLK_SEL_LSB] == RIF_CLK_RC);
  assign o_aux_out_pin   = st_ff.pins;

  // Undivided and RC codes pass the source clock straight through
  always_comb begin
    unique case (st_ff.route_b[2:RIF_B_CLK_SEL_LSB])
      3'h0:        o_divided_clock_pin = i_mclk;
      RIF_CLK_RC:  o_divided_clock_pin = i_rc_osc;
      RIF_CLK_OFF: o_divided_clock_pin = 1'b0;
      default:     o_divided_clock_pin = st_ff.clk_pin;
    endcase
  end

endmodule : rif_top

`default_nettype wire

// ---- design/rif_pkg.sv ----
/*
  Constants and types shared by the radio event-flag and pin-routing block.
  Assumes an APB master on the register side and a radio core on one clock.
*/
package rif_pkg;

  // ---------------------------------------------------------------------
  // Operating modes
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    RIF_MODE_SLEEP,
    RIF_MODE_STANDBY,
    RIF_MODE_SYNTH,
    RIF_MODE_RX,
    RIF_MODE_TX
  } rif_mode_t;

  // ---------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam logic [7:0] RIF_IDX_ROUTE_A   = 8'h25;
  localparam logic [7:0] RIF_IDX_ROUTE_B   = 8'h26;
  localparam logic [7:0] RIF_IDX_FLAGS1    = 8'h27;
  localparam logic [7:0] RIF_IDX_FLAGS2    = 8'h28;
  localparam logic [7:0] RIF_IDX_LEVEL     = 8'h29;
  localparam logic [7:0] RIF_IDX_WAIT1     = 8'h2a;
  localparam logic [7:0] RIF_IDX_WAIT2     = 8'h2b;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] RIF_RST_ROUTE_A   = 8'h00;
  localparam logic [7:0] RIF_RST_ROUTE_B   = 8'h07;
  localparam logic [7:0] RIF_RST_FLAGS1    = 8'h80;
  localparam logic [7:0] RIF_RST_FLAGS2    = 8'h00;
  localparam logic [7:0] RIF_RST_LEVEL     = 8'he4;
  localparam logic [7:0] RIF_RST_WAIT      = 8'h00;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int RIF_B_CLK_SEL_LSB   = 0;
  localparam int RIF_B_ROUTE_B_RSVD  = 3;
  localparam int RIF_F1_MODE_SETTLED = 7;
  localparam int RIF_F1_RX_SETTLED   = 6;
  localparam int RIF_F1_TX_SETTLED   = 5;
  localparam int RIF_F1_SYNTH_LOCKED = 4;
  localparam int RIF_F1_STRENGTH     = 3;
  localparam int RIF_F1_TIMEOUT      = 2;
  localparam int RIF_F1_INTERMEDIATE = 1;
  localparam int RIF_F1_FRAME_MATCH  = 0;
  localparam int RIF_F2_QUEUE_FULL   = 7;
  localparam int RIF_F2_NONEMPTY     = 6;
  localparam int RIF_F2_ABOVE_MARK   = 5;
  localparam int RIF_F2_OVERFLOW     = 4;
  localparam int RIF_F2_TRANSMITTED  = 3;
  localparam int RIF_F2_BODY_RECV    = 2;
  localparam int RIF_F2_CHECK_PASSED = 1;
  localparam int RIF_F2_BATTERY_LOW  = 0;

  // ---------------------------------------------------------------------
  // Clock output codes, queue size and timing
  // ---------------------------------------------------------------------
  localparam logic [2:0] RIF_CLK_DIV32     = 3'h5;
  localparam logic [2:0] RIF_CLK_RC        = 3'h6;
  localparam logic [2:0] RIF_CLK_OFF       = 3'h7;
  localparam logic [6:0] RIF_QUEUE_DEPTH   = 7'h42;
  localparam int         RIF_BITS_PER_UNIT = 16;

endpackage : rif_pkg

// ---- design/rif_tmo_if.sv ----
/*
  Interface between the flag logic and one receive timeout counter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

interface rif_tmo_if;
  logic       arm;
  logic [7:0] units;
  logic       bit_tick;
  logic       expire;

  modport ctl (output arm, output units, output bit_tick, input expire);
  modport cnt (input arm, input units, input bit_tick, output expire);
endinterface : rif_tmo_if

`default_nettype wire

// ---- design/rif_timeout.sv ----
/*
  One receive timeout counter: counts units of sixteen bit periods while armed.
  Assumes bit_tick is a one-cycle pulse per bit period on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module rif_timeout (
  input  wire logic i_mclk,
  input  wire logic i_reset,
  rif_tmo_if.cnt    tmo
);
  import rif_pkg::*;

  typedef struct packed {
    logic       arm_d;
    logic [3:0] pre;
    logic [7:0] cnt;
    logic       done;
    logic       expire;
  } rif_tmo_state_t;

  rif_tmo_state_t st_ff;
  rif_tmo_state_t nxt_st;

  // ---------------------------------------------------------------------
  // Counting
  // ---------------------------------------------------------------------
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.arm_d  = tmo.arm;
    nxt_st.expire = 1'b0;
    if (!tmo.arm || !st_ff.arm_d) begin
      // Fresh start on every new arming
      nxt_st.pre  = 4'h0;
      nxt_st.cnt  = 8'h00;
      nxt_st.done = 1'b0;
    end else if (tmo.bit_tick && !st_ff.done && tmo.units != 8'h00) begin
      nxt_st.pre = st_ff.pre + 4'h1;
      if (st_ff.pre == 4'(RIF_BITS_PER_UNIT - 1)) begin
        nxt_st.cnt = st_ff.cnt + 8'h01;
        if (st_ff.cnt + 8'h01 == tmo.units) begin
          nxt_st.expire = 1'b1;
          nxt_st.done   = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tmo.expire = st_ff.expire;

endmodule : rif_timeout

`default_nettype wire

// ---- tb/rif_top_sva.sv ----
/*
  Port checker for rif_top, bound to the top module.
  Assumes one clock domain with synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none

module rif_top_sva (
  input wire logic               i_mclk,
  input wire logic               i_reset,
  input wire logic               i_psel,
  input wire logic               i_penable,
  input wire logic               i_pwrite,
  input wire logic [11:0]        i_paddr,
  input wire logic [31:0]        i_pwdata,
  input wire logic [3:0]         i_pstrb,
  input wire logic               o_pready,
  input wire logic [31:0]        o_prdata,
  input wire logic               o_pslverr,
  input wire rif_pkg::rif_mode_t i_op_mode,
  input wire logic               i_payload_done,
  input wire logic               i_check_pass,
  input wire logic               i_check_enable,
  input wire logic               i_keep_on_check_fail,
  input wire logic               i_rc_osc,
  input wire logic               o_queue_clear,
  input wire logic               o_rc_osc_enable,
  input wire logic               o_divided_clock_pin
);
  import rif_pkg::*;
  logic       acc;
  logic       wacc;
  logic       fail;
  logic [7:0] idx;
  assign acc = i_psel && i_penable;
  assign wacc = acc && i_pwrite && i_pstrb[0];
  assign idx = i_paddr[9:2];
  assign fail = i_payload_done && i_op_mode == RIF_MODE_RX && !i_check_pass;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  no_wait_a:
    assert property (i_psel && !i_penable ##1 acc |-> o_pready && o_prdata[31:8] == 24'h0)
    else $error("access without pready or with wide read data");
  bad_index_a:
    assert property (acc |-> o_pslverr == (idx < RIF_IDX_ROUTE_A || idx > RIF_IDX_WAIT2))
    else $error("slave error does not match address map");
  ovf_clear_a:
    assert property (wacc && idx == RIF_IDX_FLAGS2 && i_pwdata[4] |=> o_queue_clear)
    else $error("overflow write did not empty queue");
  clear_pulse_a:
    assert property ($rose(o_queue_clear) |=> !o_queue_clear)
    else $error("queue clear longer than one cycle");
  fail_flush_a:
    assert property (fail && i_check_enable && !i_keep_on_check_fail |-> ##[1:2] o_queue_clear)
    else $error("failed check did not flush queue");
  keep_queue_a:
    assert property (fail && i_keep_on_check_fail && !acc |=> !o_queue_clear [*2])
    else $error("queue flushed although keep is set");
  rc_route_a:
    assert property (o_rc_osc_enable |-> o_divided_clock_pin == i_rc_osc)
    else $error("clock pin not carrying rc oscillator");
  clk_off_rst_a:
    assert property ($fell(i_reset) |-> !o_rc_osc_enable && !o_divided_clock_pin)
    else $error("clock output not off after reset");
  rc_stable_a:
    assert property (!(wacc && idx == RIF_IDX_ROUTE_B) |=> $stable(o_rc_osc_enable))
    else $error("rc enable changed without a write");
  cover property (wacc && idx == RIF_IDX_FLAGS2 && i_pwdata[4]);
  cover property ($rose(o_rc_osc_enable));
  cover property (fail && i_check_enable ##[1:2] o_queue_clear);
endmodule // rif_top_sva

bind rif_top rif_top_sva rif_top_sva_i (.*);

`default_nettype wire

// ---- tb/rif_top_tb.sv ----
/*
  Self-checking bench for rif_top: registers over APB, flags, pins, clock out.
  Assumes rif_pkg, the design and the checker are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none

module rif_top_tb;
  import rif_pkg::*;
  logic            i_mclk = 1'b0, i_reset = 1'b1;
  logic            i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0]     i_paddr = 12'h0;
  logic [31:0]     i_pwdata = 32'h0;
  logic [3:0]      i_pstrb = 4'hf;
  logic            o_pready, o_pslverr, o_queue_clear, o_rc_osc_enable, o_divided_clock_pin;
  logic [31:0]     o_prdata;
  logic [5:0]      o_aux_out_pin;
  rif_mode_t       i_op_mode = RIF_MODE_STANDBY;
  logic            i_mode_ready_evt = 1'b0, i_rx_settle_done = 1'b0, i_pa_ramp_done = 1'b0;
  logic            i_pll_locked = 1'b0, i_intermediate_active = 1'b0, i_frame_match_evt = 1'b0;
  logic            i_continuous_mode = 1'b0, i_overrun_evt = 1'b0, i_packet_done = 1'b0;
  logic            i_payload_done = 1'b0, i_check_pass = 1'b0, i_check_enable = 1'b0;
  logic            i_keep_on_check_fail = 1'b0, i_bit_tick = 1'b0, i_battery_below = 1'b0;
  logic            i_rc_osc = 1'b0;
  logic [7:0]      i_strength_measure = 8'h0;
  logic [6:0]      i_queue_count = 7'h0, i_queue_mark = 7'h0;
  logic [5:0][3:0] i_route_cand_packet = '0, i_route_cand_cont = '0;
  int              miscompares = 0, check_count = 0, cycles = 0;

  rif_top rif_top_i (.*);

  always #5 i_mclk = ~i_mclk;

  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  // ---------------------------------------------------------------------
  // Tasks and expectations
  // ---------------------------------------------------------------------
  task automatic close_out();
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r, output logic e);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= {2'h0, a, 2'h0};
    i_pwdata <= {24'h0, d};
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    r = o_prdata[7:0];
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    logic [7:0] r;
    logic       e;
    apb(1'b0, a, 8'h0, r, e);
    chk(r & m, x);
  endtask

  // Bit order: ready, settle, ramp, match, overrun, sent, payload
  task automatic pulse(input int n);
    {i_mode_ready_evt, i_rx_settle_done, i_pa_ramp_done, i_frame_match_evt,
     i_overrun_evt, i_packet_done, i_payload_done} <= 7'h40 >> n;
    @(posedge i_mclk);
    {i_mode_ready_evt, i_rx_settle_done, i_pa_ramp_done, i_frame_match_evt,
     i_overrun_evt, i_packet_done, i_payload_done} <= '0;
    @(posedge i_mclk);
  endtask

  function automatic logic [5:0] pin_exp(logic [7:0] a, logic [7:0] b, logic [5:0][3:0] cd);
    logic [11:0] s;
    s = {a, b[7:4]};
    for (int i = 0; i < 6; i++) pin_exp[i] = cd[i][s[11-2*i -: 2]];
  endfunction

  function automatic logic [7:0] clk_exp(int c, bit edges);
    if (c == 7) return 8'h00;
    if (c == 0 || c == 6) return edges ? 8'h00 : 8'h40;
    return edges ? 8'h40 >> (c - 1) : 8'h20;
  endfunction

  function automatic logic [7:0] q_exp(logic [6:0] n, logic [6:0] m);
    return {n == 7'h42, n != 7'h00, n > m, 5'h00};
  endfunction

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    logic [7:0]  v, ra, rb, e8;
    logic        e;
    logic        p;
    int          ones, tr;
    logic [13:0] qv;
    logic [7:0]  rst_tab [7] = '{8'h00, 8'h07, 8'h80, 8'h00, 8'he4, 8'h00, 8'h00};
    logic [7:0]  rw_idx [5] = '{8'h25, 8'h26, 8'h29, 8'h2a, 8'h2b};
    logic [13:0] q_tab [4] = '{{7'h42, 7'h41}, {7'h42, 7'h42}, {7'h01, 7'h00}, 14'h0};
    void'($urandom(46));
    repeat (10) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
    for (int k = 0; k < 7; k++) rdm(RIF_IDX_ROUTE_A + 8'(k), 8'hff, rst_tab[k]);
    apb(1'b0, 8'h30, 8'h0, e8, e);
    chk({7'h0, e}, 8'h01);
    chk(e8, 8'h00);
    for (int k = 0; k < 5; k++) begin
      v = 8'($urandom);
      wr(rw_idx[k], v);
      rdm(rw_idx[k], 8'hff, k == 1 ? v & 8'hf7 : v);
    end
    for (int c = 0; c < 3; c++) begin
      ra = c == 0 ? 8'h1b : 8'($urandom);
      rb = {4'($urandom), 4'h7};
      i_route_cand_packet <= 24'($urandom);
      i_route_cand_cont <= 24'($urandom);
      i_continuous_mode <= c[0];
      wr(RIF_IDX_ROUTE_A, ra);
      wr(RIF_IDX_ROUTE_B, rb);
      repeat (2) @(posedge i_mclk);
      chk({2'h0, o_aux_out_pin}, {2'h0, pin_exp(ra, rb, c[0] ? i_route_cand_cont : i_route_cand_packet)});
    end
    for (int c = 0; c < 8; c++) begin
      i_rc_osc <= (c == 6);
      wr(RIF_IDX_ROUTE_B, {5'h0, 3'(c)});
      repeat (4) @(posedge i_mclk);
      #1;
      p = o_divided_clock_pin;
      ones = 0;
      tr = 0;
      repeat (64) begin
        @(posedge i_mclk);
        #1;
        ones += (o_divided_clock_pin === 1'b1);
        tr += (o_divided_clock_pin !== p);
        p = o_divided_clock_pin;
      end
      chk(8'(ones), clk_exp(c, 1'b0));
      chk(8'(tr), clk_exp(c, 1'b1));
      chk({7'h0, o_rc_osc_enable}, {7'h0, c == 6});
    end
    i_continuous_mode <= 1'b0;
    wr(RIF_IDX_LEVEL, 8'h40);
    wr(RIF_IDX_WAIT1, 8'h01);
    wr(RIF_IDX_WAIT2, 8'h01);
    i_strength_measure <= 8'h40;
    i_op_mode <= RIF_MODE_RX;
    i_bit_tick <= 1'b1;
    repeat (8) @(posedge i_mclk);
    rdm(RIF_IDX_FLAGS1, 8'h8c, 8'h00);
    repeat (20) @(posedge i_mclk);
    rdm(RIF_IDX_FLAGS1, 8'h0c, 8'h04);
    i_bit_tick <= 1'b0;
    i_strength_measure <= 8'h41;
    i_intermediate_active <= 1'b1;
    pulse(1);
    pulse(3);
    pulse(0);
    rdm(RIF_IDX_FLAGS1, 8'hcf, 8'hcf);
    i_strength_measure <= 8'h00;
    wr(RIF_IDX_FLAGS1, 8'h09);
    rdm(RIF_IDX_FLAGS1, 8'h09, 8'h01);
    i_continuous_mode <= 1'b1;
    wr(RIF_IDX_FLAGS1, 8'h01);
    rdm(RIF_IDX_FLAGS1, 8'h01, 8'h00);
    i_queue_count <= 7'h05;
    i_check_enable <= 1'b1;
    pulse(6);
    rdm(RIF_IDX_FLAGS2, 8'h06, 8'h00);
    rdm(RIF_IDX_FLAGS1, 8'h04, 8'h00);
    i_strength_measure <= 8'h41;
    i_bit_tick <= 1'b1;
    repeat (20) @(posedge i_mclk);
    rdm(RIF_IDX_FLAGS1, 8'h0c, 8'h0c);
    i_bit_tick <= 1'b0;
    i_keep_on_check_fail <= 1'b1;
    pulse(6);
    rdm(RIF_IDX_FLAGS2, 8'h06, 8'h04);
    i_check_pass <= 1'b1;
    pulse(6);
    rdm(RIF_IDX_FLAGS2, 8'h06, 8'h06);
    i_queue_count <= 7'h00;
    repeat (2) @(posedge i_mclk);
    rdm(RIF_IDX_FLAGS2, 8'h06, 8'h00);
    i_intermediate_active <= 1'b0;
    i_op_mode <= RIF_MODE_STANDBY;
    repeat (2) @(posedge i_mclk);
    rdm(RIF_IDX_FLAGS1, 8'h4f, 8'h00);
    for (int k = 0; k < 8; k++) begin
      qv = k < 4 ? q_tab[k] : {7'($urandom_range(66)), 7'($urandom)};
      {i_queue_count, i_queue_mark} <= qv;
      repeat (2) @(posedge i_mclk);
      rdm(RIF_IDX_FLAGS2, 8'he0, q_exp(qv[13:7], qv[6:0]));
    end
    pulse(4);
    rdm(RIF_IDX_FLAGS2, 8'h10, 8'h10);
    wr(RIF_IDX_FLAGS2, 8'h10);
    rdm(RIF_IDX_FLAGS2, 8'h10, 8'h00);
    i_op_mode <= RIF_MODE_SLEEP;
    pulse(4);
    rdm(RIF_IDX_FLAGS2, 8'h10, 8'h00);
    i_battery_below <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_battery_below <= 1'b0;
    repeat (4) @(posedge i_mclk);
    rdm(RIF_IDX_FLAGS2, 8'h01, 8'h01);
    wr(RIF_IDX_FLAGS2, 8'h01);
    rdm(RIF_IDX_FLAGS2, 8'h01, 8'h00);
    i_op_mode <= RIF_MODE_TX;
    i_pll_locked <= 1'b1;
    pulse(2);
    pulse(5);
    rdm(RIF_IDX_FLAGS1, 8'h30, 8'h30);
    rdm(RIF_IDX_FLAGS2, 8'h08, 8'h08);
    i_pll_locked <= 1'b0;
    repeat (2) @(posedge i_mclk);
    rdm(RIF_IDX_FLAGS1, 8'h10, 8'h00);
    i_op_mode <= RIF_MODE_STANDBY;
    repeat (2) @(posedge i_mclk);
    rdm(RIF_IDX_FLAGS1, 8'h20, 8'h00);
    rdm(RIF_IDX_FLAGS2, 8'h08, 8'h00);
    close_out();
  end
endmodule // rif_top_tb

`default_nettype wire
